//--- design/refclk_consts.svh
`ifndef REFCLK_CONSTS_SVH
`define REFCLK_CONSTS_SVH

// Register offsets on the device register port.
`define CTRL_ADDR        6'h03
`define OSC_ADDR         6'h12

// Clock-output control register layout and reset values.
`define TIMING_BIT       7
`define PHASE_BIT        5
`define PHASE_INV_BIT    4
`define DEFER_BIT        3
`define RATE_MSB         2
`define RATE_RESET       3'h1
`define DEFER_RESET      1'b1
`define RATE_OFF         3'h0
`define RATE_FAST_MAX    3'h5

// Oscillator control register layout and reset values.
`define MODE_MSB         7
`define MODE_LSB         4
`define TRIM_MSB         3
`define MODE_EXTERNAL    4'h5
`define MODE_RESET       4'hF
`define TRIM_RESET       4'h0

// Timing.
`define CLK_MHZ          100
`define REF_MHZ          16
`define CLK_PERIOD_NS    10
`define SLEEP_SETTLE_NS  180000
`define DEEP_SETTLE_NS   330000
`define DRAIN_CYCLES     35

`endif

//--- design/refclk_pkg.sv
`include "refclk_consts.svh"

package refclk_pkg;

    typedef logic [2:0] rate_code_t;

    // Power states seen by the clock output logic.
    typedef enum logic [2:0] {
        ST_RUN,
        ST_DRAIN,
        ST_SLEEP,
        ST_DEEP,
        ST_WAKE
    } pwr_state_t;

    // Half-period length in 32 MHz half-ticks for each output-rate code.
    function automatic logic [8:0] half_len(input rate_code_t code);
        logic [8:0] len;
        len = 9'h001;
        unique case (code)
            3'h1: len = 9'h010;
            3'h2: len = 9'h008;
            3'h3: len = 9'h004;
            3'h4: len = 9'h002;
            3'h5: len = 9'h001;
            3'h6: len = 9'h040;
            3'h7: len = 9'h100;
            3'h0: len = 9'h001;
        endcase
        return len;
    endfunction

endpackage

//--- design/clock_prescaler.sv
`timescale 1ns/1ps
`include "refclk_consts.svh"

module clock_prescaler
    import refclk_pkg::*;
#(
    parameter int CLK_MHZ = `CLK_MHZ,
    parameter int REF_MHZ = `REF_MHZ
) (
    input  wire logic       clk,
    input  wire logic       porResetn,
    input  wire logic       run,
    input  wire rate_code_t rateCode,
    output logic            clkOut,
    output logic            fallPulse
);

    localparam logic [7:0] STEP = 8'(2 * REF_MHZ);
    localparam logic [7:0] WRAP = 8'(CLK_MHZ);

    logic [7:0] acc_q;
    logic       halfTick;
    logic [8:0] halfCnt_q;
    rate_code_t curCode_q;

    // Fractional accumulator: half-ticks of the 16 MHz reference on average.
    assign halfTick = (acc_q + STEP) >= WRAP;

    always_ff @(posedge clk) begin
        if (!porResetn) begin
            acc_q <= 8'h00;
        end else if (halfTick) begin
            acc_q <= acc_q + STEP - WRAP;
        end else begin
            acc_q <= acc_q + STEP;
        end
    end

    // A new code is adopted only where a whole half period ends, so a rate
    // change never shortens a pulse on the pin; code zero parks the pin low.
    always_ff @(posedge clk) begin
        if (!porResetn || !run) begin
            clkOut    <= 1'b0;
            halfCnt_q <= 9'h000;
            curCode_q <= rateCode;
            fallPulse <= 1'b0;
        end else begin
            fallPulse <= 1'b0;
            if (halfTick) begin
                if (halfCnt_q + 9'h001 >= half_len(curCode_q)) begin
                    halfCnt_q <= 9'h000;
                    if (clkOut) begin
                        clkOut    <= 1'b0;
                        fallPulse <= 1'b1;
                        curCode_q <= rateCode;
                    end else begin
                        curCode_q <= rateCode;
                        clkOut    <= (rateCode != `RATE_OFF);
                    end
                end else begin
                    halfCnt_q <= halfCnt_q + 9'h001;
                end
            end
        end
    end

endmodule

//--- design/reference_clock_output_control.sv
`timescale 1ns/1ps
`include "refclk_consts.svh"

//Contract
// RULE1 - Prescaled 16 MHz reference drives output pin.
// RULE2 - Defer clear: rate change immediate, glitch free.
// RULE3 - Defer set, rate nonzero: apply on wake.
// RULE4 - Reset keeps running rate, field reads one.
// RULE5 - Unrewritten field returns clock to 1 MHz.
// RULE6 - Software rewrites old rate after reset.
// RULE7 - Deep_power_down_state exit: 1 MHz after oscillator settles.
// RULE8 - Software turns clock off when unused.
// RULE9 - Control register 0x03: defer bit3, rate 2:0.
// RULE10 - Oscillator ready 180 us or 330 us.
// RULE11 - Trim field selects load capacitance steps.
// RULE12 - Software selects external mode for external reference.
// RULE13 - Rate codes map zero off through 62.5 kHz.
// RULE14 - Mode 0x5 external, 0xF internal oscillator.
// RULE15 - Thirty-five extra clocks before entering sleep; the code drains only at rate codes 1 to 5, not 6 or 7.
// RULE16 - Deferred rate held in shadow until wake.
module reference_clock_output_control
    import refclk_pkg::*;
#(
    parameter int SLEEP_SETTLE_CYC =
        (`SLEEP_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int DEEP_SETTLE_CYC =
        (`DEEP_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int DRAIN_CYCLES = `DRAIN_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       porResetn,
    input  wire logic [5:0] regAddr,
    input  wire logic       regWrEn,
    input  wire logic       regRdEn,
    input  wire logic [7:0] regWrData,
    output logic      [7:0] regRdData,
    input  wire logic       sleepTransmitPin,
    input  wire logic       radioIdleState,
    input  wire logic       deepSleepSel,
    input  wire logic       wakeReq,
    output logic            hostClockOut,
    output logic            oscRunning,
    output logic            oscInternalEnable,
    output logic      [3:0] oscLoadTrim,
    output logic            clockReady,
    output rate_code_t      activeRateCode,
    output logic            timingMeasureEnable,
    output logic            phaseMeasureEnable,
    output logic            phaseMeasureIfInvert
);

    rate_code_t  rateField_q;
    logic        deferSel_q;
    rate_code_t  activeRate_q;
    logic  [3:0] oscMode_q;
    logic  [3:0] oscTrim_q;
    pwr_state_t  state_q;
    logic        deepTarget_q;
    logic [15:0] settleCnt_q;
    logic  [5:0] drainCnt_q;
    logic        wrCtrl;
    logic        wrOsc;
    logic        rateDeferred;
    logic        exitSleep;
    logic        exitDeep;
    logic        sleepAsk;
    logic        fastRate;
    logic        fallPulse;
    logic        divRun;
    rate_code_t  wrRate;
    logic        ctrlRewritten_q;

    // Register port decode; writes are ignored while reset is held.
    assign wrCtrl = resetn && regWrEn && (regAddr == `CTRL_ADDR);
    assign wrOsc  = resetn && regWrEn && (regAddr == `OSC_ADDR);
    assign wrRate = regWrData[`RATE_MSB:0];

    // RULE3 defer decision
    // A write defers only when deferral is selected and the rate field held a nonzero code.
    assign rateDeferred = regWrData[`DEFER_BIT] && (rateField_q != `RATE_OFF);

    assign exitSleep = resetn && (state_q == ST_SLEEP) && wakeReq;
    assign exitDeep  = resetn && (state_q == ST_DEEP) && wakeReq;
    assign sleepAsk  = sleepTransmitPin && radioIdleState;
    assign fastRate  = (activeRate_q != `RATE_OFF)
                    && (activeRate_q <= `RATE_FAST_MAX);

    // RULE9 control register
    // The visible register fields go back to their reset values on resetn.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            // RULE5 field default
            rateField_q          <= `RATE_RESET;
            deferSel_q           <= `DEFER_RESET;
            timingMeasureEnable  <= 1'b0;
            phaseMeasureEnable   <= 1'b0;
            phaseMeasureIfInvert <= 1'b0;
        end else if (wrCtrl) begin
            rateField_q          <= wrRate;
            deferSel_q           <= regWrData[`DEFER_BIT];
            timingMeasureEnable  <= regWrData[`TIMING_BIT];
            phaseMeasureEnable   <= regWrData[`PHASE_BIT];
            phaseMeasureIfInvert <= regWrData[`PHASE_INV_BIT];
        end
    end

    // RULE4 rate survives reset
    // The running rate is reset only at power-on, so a soft reset leaves the
    // pin running while the field reads the default. Immediate writes win over a wake.
    always_ff @(posedge clk) begin
        if (!porResetn) begin
            activeRate_q <= `RATE_RESET;
        end else if (wrCtrl && !rateDeferred) begin
            // RULE2 immediate change
            activeRate_q <= wrRate;
        end else if (exitSleep) begin
            // RULE16 shadow to active
            activeRate_q <= rateField_q;
        end else if (exitDeep) begin
            // RULE7 deep wake default
            activeRate_q <= `RATE_RESET;
        end
    end

    // RULE5 rewrite tracker
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrlRewritten_q <= 1'b0;
        end else if (wrCtrl) begin
            ctrlRewritten_q <= 1'b1;
        end
    end

    // RULE14 oscillator control register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            oscMode_q <= `MODE_RESET;
            oscTrim_q <= `TRIM_RESET;
        end else if (wrOsc) begin
            oscMode_q <= regWrData[`MODE_MSB:`MODE_LSB];
            oscTrim_q <= regWrData[`TRIM_MSB:0];
        end
    end

    // RULE11 trim pass-through
    // Each code is one 0.3 pF step of load capacitance, all codes valid.
    assign oscLoadTrim = oscTrim_q;

    // Reserved mode values keep the internal oscillator on, the safe choice.
    assign oscRunning        = (state_q != ST_SLEEP) && (state_q != ST_DEEP);
    assign oscInternalEnable = oscRunning && (oscMode_q != `MODE_EXTERNAL);
    assign clockReady        = (state_q == ST_RUN) || (state_q == ST_DRAIN);
    assign activeRateCode    = activeRate_q;

    // Read data is captured on the read strobe; unmapped offsets read zero.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            regRdData <= 8'h00;
        end else if (regRdEn) begin
            unique case (regAddr)
                `CTRL_ADDR: regRdData <= {timingMeasureEnable, 1'b0,
                                          phaseMeasureEnable,
                                          phaseMeasureIfInvert,
                                          deferSel_q, rateField_q};
                `OSC_ADDR:  regRdData <= {oscMode_q, oscTrim_q};
                default:    regRdData <= 8'h00;
            endcase
        end
    end

    // Power sequencing. Reset leaves sleep states straight for the run state, so
    // the oscillator gets no settle time when reset is taken from there.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q      <= ST_RUN;
            deepTarget_q <= 1'b0;
            drainCnt_q   <= 6'h00;
            settleCnt_q  <= 16'h0000;
        end else begin
            unique case (state_q)
                ST_RUN: begin
                    if (sleepAsk) begin
                        deepTarget_q <= deepSleepSel;
                        drainCnt_q   <= 6'h00;
                        // RULE15 drain before sleep
                        if (fastRate) begin
                            state_q <= ST_DRAIN;
                        end else begin
                            state_q <= deepSleepSel ? ST_DEEP : ST_SLEEP;
                        end
                    end
                end
                ST_DRAIN: begin
                    if (fallPulse) begin
                        // RULE15 count extra cycles
                        if (drainCnt_q == 6'(DRAIN_CYCLES - 1)) begin
                            state_q <= deepTarget_q ? ST_DEEP : ST_SLEEP;
                        end
                        drainCnt_q <= drainCnt_q + 6'h01;
                    end
                end
                ST_SLEEP, ST_DEEP: begin
                    // RULE10 settle time
                    if (wakeReq) begin
                        state_q     <= ST_WAKE;
                        settleCnt_q <= (state_q == ST_DEEP)
                                     ? 16'(DEEP_SETTLE_CYC - 1)
                                     : 16'(SLEEP_SETTLE_CYC - 1);
                    end
                end
                ST_WAKE: begin
                    if (settleCnt_q == 16'h0000) begin
                        state_q <= ST_RUN;
                    end else begin
                        settleCnt_q <= settleCnt_q - 16'h0001;
                    end
                end
            endcase
        end
    end

    // RULE1 prescaler
    // The pin only toggles while clockReady is set, in the run and drain states.
    assign divRun = clockReady;

    // RULE13 rate decode
    clock_prescaler u_prescaler (
        .clk       (clk),
        .porResetn (porResetn),
        .run       (divRun),
        .rateCode  (activeRate_q),
        .clkOut    (hostClockOut),
        .fallPulse (fallPulse)
    );

    // RULE2 immediate write
    a_rate_immediate: assert property ( // RULE2
        @(posedge clk) disable iff (!resetn) wrCtrl && !rateDeferred
        |=> activeRate_q == $past(wrRate))
        else $error("immediate rate write not applied");

    // RULE3 deferred write
    a_rate_deferred: assert property ( // RULE3
        @(posedge clk) disable iff (!resetn) wrCtrl && rateDeferred
        && !exitSleep && !exitDeep |=> $stable(activeRate_q))
        else $error("deferred rate write changed running rate");

    // RULE16 shadow copy
    a_shadow_copy: assert property ( // RULE16
        @(posedge clk) disable iff (!resetn) exitSleep && !wrCtrl
        |=> activeRate_q == $past(rateField_q))
        else $error("sleep exit did not copy shadow rate");

    // RULE7 deep default
    a_deep_default: assert property ( // RULE7
        @(posedge clk) disable iff (!resetn) exitDeep && !wrCtrl
        |=> activeRate_q == `RATE_RESET ##1 (state_q == ST_WAKE) [*8])
        else $error("deep exit did not restart at default rate");

    // RULE4 reset keeps rate
    a_reset_keeps: assert property ( // RULE4
        @(posedge clk) disable iff (!porResetn) !resetn
        |=> $stable(activeRate_q) && rateField_q == `RATE_RESET
        && deferSel_q == `DEFER_RESET)
        else $error("reset disturbed running rate or field value");

    // RULE5 fallback after sleep
    a_fallback: assert property ( // RULE5
        @(posedge clk) disable iff (!resetn) exitSleep && !wrCtrl
        && !ctrlRewritten_q |=> activeRate_q == `RATE_RESET)
        else $error("rate did not fall back after sleep");

    // RULE10 dark while settling
    a_dark_settle: assert property ( // RULE10
        @(posedge clk) disable iff (!resetn) state_q == ST_WAKE
        |=> !hostClockOut || state_q == ST_RUN)
        else $error("clock driven before oscillator settled");

    // RULE15 drain length
    a_drain_count: assert property ( // RULE15
        @(posedge clk) disable iff (!resetn) state_q == ST_DRAIN && fallPulse
        && drainCnt_q == 6'(DRAIN_CYCLES - 1)
        |=> state_q == ST_SLEEP || state_q == ST_DEEP)
        else $error("drain did not end after extra cycles");

    // RULE13 code zero holds low
    a_off_low: assert property ( // RULE13
        @(posedge clk) disable iff (!resetn)
        !hostClockOut && activeRate_q == `RATE_OFF
        |=> !hostClockOut)
        else $error("pin rose with output rate off");

endmodule

//--- dv/host_clock_monitor.sv
`timescale 1ns/1ps

// Host clocked from the output pin; it counts the edges it receives so the
// bench can reckon the delivered rate over a window of system clocks.
module host_clock_monitor (
    input  wire logic hostClockOut,
    output int        riseCount,
    output int        fallCount
);

    // Counters start at zero so the first edge after reset is counted once.
    initial begin
        riseCount = 0;
        fallCount = 0;
    end

    always @(posedge hostClockOut) begin
        riseCount <= riseCount + 1;
    end

    always @(negedge hostClockOut) begin
        fallCount <= fallCount + 1;
    end

endmodule

//--- dv/reference_clock_output_control_tb_top.sv
`timescale 1ns/1ps

`include "refclk_consts.svh"

module reference_clock_output_control_tb_top
    import refclk_pkg::*;
;
    logic       clk = 0, resetn = 0, porResetn = 0;
    logic [5:0] regAddr = 6'h00;
    logic       regWrEn = 0, regRdEn = 0;
    logic [7:0] regWrData = 8'h00, regRdData, rd;
    logic       sleepTransmitPin = 0, radioIdleState = 1;
    logic       deepSleepSel = 0, wakeReq = 0;
    logic       hostClockOut, oscRunning, oscInternalEnable, clockReady;
    logic [3:0] oscLoadTrim;
    rate_code_t activeRateCode;
    logic       timingMeasureEnable, phaseMeasureEnable;
    logic       phaseMeasureIfInvert;
    int         riseCount, fallCount, failures = 0, samplesChecked = 0;
    int         n;

    // Short settle counts keep the run brief; expectations use these values.
    localparam int SLEEP_CYC = 20;
    localparam int DEEP_CYC = 40;

    always #5 clk = ~clk;

    reference_clock_output_control #(
        .SLEEP_SETTLE_CYC(SLEEP_CYC), .DEEP_SETTLE_CYC(DEEP_CYC),
        .DRAIN_CYCLES(35)
    ) DUT (
        .clk(clk), .resetn(resetn), .porResetn(porResetn),
        .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regWrData(regWrData), .regRdData(regRdData),
        .sleepTransmitPin(sleepTransmitPin),
        .radioIdleState(radioIdleState), .deepSleepSel(deepSleepSel),
        .wakeReq(wakeReq), .hostClockOut(hostClockOut),
        .oscRunning(oscRunning), .oscInternalEnable(oscInternalEnable),
        .oscLoadTrim(oscLoadTrim), .clockReady(clockReady),
        .activeRateCode(activeRateCode),
        .timingMeasureEnable(timingMeasureEnable),
        .phaseMeasureEnable(phaseMeasureEnable),
        .phaseMeasureIfInvert(phaseMeasureIfInvert)
    );

    host_clock_monitor HOST (
        .hostClockOut(hostClockOut), .riseCount(riseCount),
        .fallCount(fallCount)
    );

    task automatic stopTest();
        $display("checked %0d, failures %0d", samplesChecked, failures);
        if (failures == 0 && samplesChecked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Case equality so an unknown output never passes for a match.
    task automatic checkVal(input logic [7:0] got, input logic [7:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic checkCnt(input int got, input int lo, input int hi);
        samplesChecked++;
        if (got < lo || got > hi) begin
            failures++;
            $display("ERROR %0t count %0d not in %0d..%0d",
                     $time, got, lo, hi);
        end
    endtask

    task automatic regWrite(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1;
        @(negedge clk);
        regWrEn = 0;
    endtask

    task automatic regRead(input logic [5:0] a);
        @(negedge clk);
        regAddr = a;
        regRdEn = 1;
        @(negedge clk);
        regRdEn = 0;
        rd = regRdData;
    endtask

    // Rising edges in 3200 system clocks for each rate code; the pin is
    // jittery per half period, so one edge of slack is allowed.
    function automatic int expEdges(input logic [2:0] c);
        int t[8] = '{0, 32, 64, 128, 256, 512, 8, 2};
        return t[c];
    endfunction

    task automatic measure(input logic [2:0] c);
        int r0;
        repeat (300) @(negedge clk);
        r0 = riseCount;
        repeat (3200) @(negedge clk);
        checkCnt(riseCount - r0, expEdges(c) - 1, expEdges(c) + 1);
    endtask

    task automatic goSleep(input logic deep, output int falls);
        int f0, k;
        @(negedge clk);
        deepSleepSel = deep;
        f0 = fallCount;
        sleepTransmitPin = 1;
        k = 0;
        while (oscRunning !== 1'b0 && k < 8000) begin
            @(negedge clk);
            k++;
        end
        sleepTransmitPin = 0;
        // A request that never reaches sleep reports an impossible count.
        falls = (k < 8000) ? fallCount - f0 : -1;
    endtask

    task automatic wakeUp(output int cyc);
        @(negedge clk);
        wakeReq = 1;
        @(negedge clk);
        wakeReq = 0;
        cyc = 1;
        while (clockReady !== 1'b1 && cyc < 2000) begin
            @(negedge clk);
            cyc++;
        end
    endtask

    task automatic softReset();
        @(negedge clk);
        resetn = 0;
        repeat (2) @(negedge clk);
        resetn = 1;
    endtask

    // A hang counts as a mismatch and ends through the same closing task.
    initial begin
        repeat (80000) @(posedge clk);
        failures++;
        $display("ERROR %0t watchdog expired", $time);
        stopTest();
    end

    initial begin
        repeat (2) @(negedge clk);
        resetn = 1;
        porResetn = 1;
        regRead(`CTRL_ADDR);
        checkVal(rd, 8'h09);
        regRead(`OSC_ADDR);
        checkVal(rd, 8'hF0);
        regRead(6'h20);
        checkVal(rd, 8'h00);
        measure(3'h1);
        $display("test reset_defaults done");

        for (int c = 0; c < 8; c++) begin
            regWrite(`CTRL_ADDR, {5'h00, 3'(c)});
            checkVal(activeRateCode, 8'(c));
            regRead(`CTRL_ADDR);
            checkVal(rd, 8'(c));
            measure(3'(c));
            if (c == 0) checkVal(hostClockOut, 8'h00);
        end
        $display("test rate_codes done");

        regWrite(`CTRL_ADDR, 8'h01);
        regWrite(`CTRL_ADDR, 8'h0D);
        checkVal(activeRateCode, 8'h01);
        regRead(`CTRL_ADDR);
        checkVal(rd, 8'h0D);
        // A sleep request while the radio is busy must be ignored.
        radioIdleState = 0;
        sleepTransmitPin = 1;
        repeat (5) @(negedge clk);
        checkVal(oscRunning, 8'h01);
        sleepTransmitPin = 0;
        radioIdleState = 1;
        goSleep(0, n);
        checkCnt(n, 35, 36);
        checkVal(activeRateCode, 8'h01);
        checkVal(hostClockOut, 8'h00);
        wakeUp(n);
        checkCnt(n, SLEEP_CYC - 1, SLEEP_CYC + 2);
        checkVal(activeRateCode, 8'h05);
        measure(3'h5);
        $display("test deferred_rate done");

        softReset();
        regRead(`CTRL_ADDR);
        checkVal(rd, 8'h09);
        checkVal(activeRateCode, 8'h05);
        measure(3'h5);
        goSleep(0, n);
        checkCnt(n, 35, 36);
        wakeUp(n);
        checkCnt(n, SLEEP_CYC - 1, SLEEP_CYC + 2);
        checkVal(activeRateCode, 8'h01);
        measure(3'h1);
        softReset();
        regWrite(`CTRL_ADDR, 8'h05);
        checkVal(activeRateCode, 8'h05);
        $display("test reset_keeps_rate done");

        goSleep(1, n);
        checkCnt(n, 35, 36);
        wakeUp(n);
        checkCnt(n, DEEP_CYC - 1, DEEP_CYC + 2);
        checkVal(activeRateCode, 8'h01);
        regRead(`CTRL_ADDR);
        checkVal(rd, 8'h05);
        measure(3'h1);
        $display("test deep_power_down_state done");

        regWrite(`OSC_ADDR, 8'h5A);
        regRead(`OSC_ADDR);
        checkVal(rd, 8'h5A);
        checkVal(oscInternalEnable, 8'h00);
        checkVal(oscLoadTrim, 8'h0A);
        regWrite(`OSC_ADDR, 8'hF3);
        checkVal(oscInternalEnable, 8'h01);
        checkVal(oscLoadTrim, 8'h03);
        $display("test oscillator_control done");

        regWrite(`CTRL_ADDR, 8'hF0);
        regRead(`CTRL_ADDR);
        checkVal(rd, 8'hB0);
        checkVal({timingMeasureEnable, phaseMeasureEnable,
                  phaseMeasureIfInvert}, 8'h07);
        measure(3'h0);
        checkVal(hostClockOut, 8'h00);
        goSleep(0, n);
        checkCnt(n, 0, 0);
        wakeUp(n);
        checkCnt(n, SLEEP_CYC - 1, SLEEP_CYC + 2);
        $display("test clock_off done");
        stopTest();
    end

endmodule
